//--- rtl/gstat_regs.svh
`ifndef GSTAT_REGS_SVH
`define GSTAT_REGS_SVH
`define OFS_CONTROL 16'h0800
`define OFS_STATUS 16'h0804
`define OFS_CLEAR 16'h0808
`define OFS_SET 16'h080c
`define OFS_VERSION 16'h0818
`define OFS_FEATURES 16'h081c
`define BIT_IDENT_EDGE 0
`define BIT_POWER_EDGE 1
`define BIT_POWER_ERR 3
`define BIT_BCONN_ERR 4
`define BIT_ROLE_SWAP 5
`define BIT_SUSP_TMO 7
`define BIT_HW_CTRL_DIS 8
`define BIT_POWER_REQ 9
`define BIT_IDENT 10
`define BIT_POWER_LVL 11
`define BIT_OTG_PAD 12
`define BIT_POLARITY 13
`define BIT_FREEZE 14
`define BIT_ENABLE 15
`define SPEED_LSB 12
`define SPEED_MSB 13
`define FLAG_MASK 8'hbb
`define CTRL_MASK 32'h0000f1bb
`define STATUS_RESET 32'h00000400
`define CONTROL_RESET 32'h00004000
`define SUSP_TMO_MS 200
`define CLK_MHZ 200
`define SUSP_TMO_CYCLES (`SUSP_TMO_MS * 1000 * `CLK_MHZ)
`endif

//--- rtl/gstat_pkg.sv
package gstat_pkg;
	typedef logic [31:0] word_t;
	typedef logic [15:0] addr_t;
	typedef logic [7:0] flags_t;
endpackage

//--- rtl/usb_otg_general_status.sv
// What this block does
// - status bits 13:12 show link speed: 00 full, 10 low, x1 reserved.
// - status bit 11 follows the sampled bus power line in either role.
// - status bit 10 mirrors the ident pin always, even when disabled.
// - power request bit 9: set by set write, cleared by clear, or by error with hardware control on.
// - supply control output is high while power request is one and polarity bit is zero.
// - suspend time-out flag bit 7 set after over 200 ms suspended with controller enabled and clock not frozen.
// - role swap flag bit 5 set on each successful role negotiation.
// - B-connection error flag bit 4 set on a connection error.
// - bus power error flag bit 3 set when bus power drops.
// - power error flag is raised even with hardware control disabled.
// - power edge flag bit 1 set on any pad edge, even clock frozen.
// - ident edge flag bit 0 set on any ident edge, whatever the mode.
// - clear register write clears status bits written as one.
// - set register write sets status bits written as one.
// - power error, power edge, ident edge enables gate their interrupt.
// - read-only version word: 12-bit version and 4-bit variant.
// - polarity bit one makes the supply control output active low.
// - with hardware control on, a power problem drops the request.
// - suspend, role swap, bconn enables gate their interrupt.
//
// The implementer's own choice: the address-and-strobe port.
`include "gstat_regs.svh"
module usb_otg_general_status #(
	parameter int unsigned TIMEOUT_CYCLES = `SUSP_TMO_CYCLES,
	// arbitrary value
	parameter logic [11:0] VERSION_NUM = 12'h001,
	// arbitrary value
	parameter logic [3:0] VARIANT_NUM = 4'h0,
	parameter logic FEAT_BYTE_WRITE = 1'b0,
	parameter logic [2:0] FEAT_FIFO_MAX = 3'h0,
	parameter logic [3:0] FEAT_DMA_DEPTH = 4'h0,
	parameter logic FEAT_DMA_BUF24 = 1'b0,
	parameter logic [2:0] FEAT_DMA_CHAN = 3'h1,
	parameter logic [3:0] FEAT_EPT_MAX = 4'h1
)(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic bus_power_pad_i,
	input wire logic ident_pin_i,
	input wire logic [1:0] link_speed_i,
	input wire logic host_suspend_i,
	input wire logic role_swap_evt_i,
	input wire logic bconn_error_evt_i,
	input wire logic power_drop_evt_i,
	output logic power_supply_control_out_o,
	output logic irq_o,
	output logic controller_enable_o,
	output logic clock_freeze_o,
	output logic dual_role_pad_enable_o
);

	localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 2);
	localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(TIMEOUT_CYCLES);
	localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(TIMEOUT_CYCLES + 1);

	function automatic logic wr_to(input gstat_pkg::addr_t ofs);
		wr_to = wr_i && (addr_i == ofs);
	endfunction

	function automatic logic rd_at(input gstat_pkg::addr_t ofs);
		rd_at = rd_i && (addr_i == ofs);
	endfunction

	// bits 1:0 synchronise the pin, bit 2 keeps the edge history
	logic [2:0] pwr_r, pwr_nxt, id_r, id_nxt;
	logic pwr_edge, id_edge;

	always_comb
	begin
		pwr_nxt = {pwr_r[1:0], bus_power_pad_i};
		id_nxt = {id_r[1:0], ident_pin_i};
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pwr_r <= 3'h0;
			id_r <= 3'h7;
		end
		else
		begin
			pwr_r <= pwr_nxt;
			id_r <= id_nxt;
		end
	end

	// edges seen regardless of enable, freeze or pad enable
	assign pwr_edge = pwr_r[1] ^ pwr_r[2];
	assign id_edge = id_r[1] ^ id_r[2];

	// control register
	gstat_pkg::word_t control_r, control_nxt;

	always_comb
	begin
		control_nxt = control_r;
		if (wr_to(`OFS_CONTROL))
			control_nxt = wdata_i & `CTRL_MASK;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			control_r <= `CONTROL_RESET;
		else
			control_r <= control_nxt;
	end

	assign controller_enable_o = control_r[`BIT_ENABLE];
	assign clock_freeze_o = control_r[`BIT_FREEZE];
	assign dual_role_pad_enable_o = control_r[`BIT_OTG_PAD];

	// suspend time-out timer, runs only with live controller clock
	logic [CNT_W-1:0] susp_cnt_r, susp_cnt_nxt;
	logic timer_run, tmo_evt;

	assign timer_run = host_suspend_i && control_r[`BIT_ENABLE]
		&& !control_r[`BIT_FREEZE];
	// fires once, after the limit has been exceeded
	assign tmo_evt = timer_run && (susp_cnt_r == CNT_LIMIT);

	always_comb
	begin
		susp_cnt_nxt = susp_cnt_r;
		if (!timer_run)
			susp_cnt_nxt = '0;
		else if (susp_cnt_r != CNT_DONE)
			susp_cnt_nxt = susp_cnt_r + 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			susp_cnt_r <= '0;
		else
			susp_cnt_r <= susp_cnt_nxt;
	end

	// status flags and power request
	gstat_pkg::flags_t flags_r, flags_nxt, hw_evt;
	logic power_request_r, power_request_nxt;
	logic req_set, req_clr, hw_drop;

	// power error raised whatever the hardware control setting
	assign hw_evt = {tmo_evt, 1'b0,
		role_swap_evt_i, bconn_error_evt_i,
		power_drop_evt_i, 1'b0,
		pwr_edge, id_edge};

	always_comb
	begin
		flags_nxt = flags_r;
		if (wr_to(`OFS_CLEAR))
			flags_nxt = flags_nxt & ~wdata_i[7:0];
		// a hardware event in the clearing cycle wins
		flags_nxt = flags_nxt | hw_evt;
		if (wr_to(`OFS_SET))
			flags_nxt = flags_nxt | wdata_i[7:0];
		flags_nxt = flags_nxt & `FLAG_MASK;
	end

	assign req_set = wr_to(`OFS_SET) && wdata_i[`BIT_POWER_REQ];
	assign req_clr = wr_to(`OFS_CLEAR) && wdata_i[`BIT_POWER_REQ];
	assign hw_drop = power_drop_evt_i && !control_r[`BIT_HW_CTRL_DIS];

	always_comb
	begin
		power_request_nxt = power_request_r;
		if (req_clr || hw_drop)
			power_request_nxt = 1'b0;
		if (req_set)
			power_request_nxt = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			flags_r <= '0;
			power_request_r <= 1'b0;
		end
		else
		begin
			flags_r <= flags_nxt;
			power_request_r <= power_request_nxt;
		end
	end

	// supply control pin, polarity applied
	logic vbof_r, vbof_nxt;

	always_comb
	begin
		vbof_nxt = power_request_nxt ^ control_nxt[`BIT_POLARITY];
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			vbof_r <= 1'b0;
		else
			vbof_r <= vbof_nxt;
	end

	assign power_supply_control_out_o = vbof_r;

	// interrupt: OR of enabled flags, level until flags or their enables cleared
	assign irq_o = |(flags_r & control_r[7:0]);

	// register read port
	gstat_pkg::word_t status_word, features_word, version_word;
	gstat_pkg::word_t rdata_r, rdata_nxt;

	always_comb
	begin
		status_word = '0;
		status_word[7:0] = flags_r;
		status_word[`BIT_POWER_REQ] = power_request_r;
		status_word[`BIT_IDENT] = id_r[1];
		status_word[`BIT_POWER_LVL] = pwr_r[1];
		status_word[`SPEED_MSB:`SPEED_LSB] = link_speed_i;
		version_word = {12'h000, VARIANT_NUM, 4'h0, VERSION_NUM};
		features_word = {16'h0000, FEAT_BYTE_WRITE, FEAT_FIFO_MAX,
			FEAT_DMA_DEPTH, FEAT_DMA_BUF24, FEAT_DMA_CHAN,
			FEAT_EPT_MAX};
	end

	always_comb
	begin
		rdata_nxt = '0;
		if (rd_i)
		begin
			case (addr_i)
				`OFS_CONTROL: rdata_nxt = control_r;
				`OFS_STATUS: rdata_nxt = status_word;
				`OFS_VERSION: rdata_nxt = version_word;
				`OFS_FEATURES: rdata_nxt = features_word;
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rdata_r <= '0;
		else
			rdata_r <= rdata_nxt;
	end

	assign rdata_o = rdata_r;

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_speed_field: assert property (
		rd_at(`OFS_STATUS) |=>
		rdata_o[13:12] == $past(link_speed_i))
		else $error("speed field does not match link speed");

	a_power_level: assert property (
		rd_at(`OFS_STATUS)
		&& bus_power_pad_i == $past(bus_power_pad_i, 1)
		&& bus_power_pad_i == $past(bus_power_pad_i, 2) |=>
		rdata_o[11] == $past(bus_power_pad_i))
		else $error("power level bit does not follow pad");

	a_ident_level: assert property (
		rd_at(`OFS_STATUS)
		&& ident_pin_i == $past(ident_pin_i, 1)
		&& ident_pin_i == $past(ident_pin_i, 2) |=>
		rdata_o[10] == $past(ident_pin_i))
		else $error("ident bit does not follow pin");

	a_req_set: assert property (
		req_set |=> power_request_r
		&& power_supply_control_out_o != control_r[`BIT_POLARITY])
		else $error("power request not set or pin not driven");

	a_req_clear: assert property (
		req_clr && !req_set |=> !power_request_r)
		else $error("power request not cleared");

	a_hw_drop: assert property (
		power_drop_evt_i && !control_r[`BIT_HW_CTRL_DIS] && !req_set
		|=> !power_request_r)
		else $error("power problem did not drop request");

	a_no_hw_drop: assert property (
		power_request_r && power_drop_evt_i
		&& control_r[`BIT_HW_CTRL_DIS] && !req_clr
		|=> power_request_r)
		else $error("request dropped with hardware control off");

	a_pin_level: assert property (
		power_request_r && !control_r[`BIT_POLARITY]
		&& $stable(power_request_r)
		&& $stable(control_r[`BIT_POLARITY])
		|-> power_supply_control_out_o)
		else $error("supply pin not high for active request");

	a_pin_inverted: assert property (
		power_request_r && control_r[`BIT_POLARITY]
		&& $stable(power_request_r)
		&& $stable(control_r[`BIT_POLARITY])
		|-> !power_supply_control_out_o)
		else $error("supply pin not inverted");

	a_tmo_flag: assert property (
		timer_run && susp_cnt_r == CNT_LIMIT
		|=> flags_r[`BIT_SUSP_TMO] && susp_cnt_r == CNT_DONE)
		else $error("suspend time-out flag missing");

	a_tmo_early: assert property (
		$rose(timer_run) |-> !tmo_evt)
		else $error("time-out fired at suspend start");

	a_role_flag: assert property (
		role_swap_evt_i |=> flags_r[`BIT_ROLE_SWAP])
		else $error("role swap flag missing");

	a_bconn_flag: assert property (
		bconn_error_evt_i |=> flags_r[`BIT_BCONN_ERR])
		else $error("bconn error flag missing");

	a_perr_flag: assert property (
		power_drop_evt_i |=> flags_r[`BIT_POWER_ERR])
		else $error("power error flag missing");

	a_pedge_flag: assert property (
		bus_power_pad_i != $past(bus_power_pad_i)
		&& !wr_to(`OFS_CLEAR) ##3 !wr_to(`OFS_CLEAR)
		|=> flags_r[`BIT_POWER_EDGE])
		else $error("power edge flag missing");

	a_iedge_flag: assert property (
		id_edge |=> flags_r[`BIT_IDENT_EDGE])
		else $error("ident edge flag missing");

	a_clear_flag: assert property (
		wr_to(`OFS_CLEAR) && !wr_to(`OFS_SET)
		&& !role_swap_evt_i && wdata_i[`BIT_ROLE_SWAP]
		|=> !flags_r[`BIT_ROLE_SWAP])
		else $error("clear write left flag set");

	a_clear_zero: assert property (
		wr_to(`OFS_CLEAR) && !wdata_i[`BIT_ROLE_SWAP]
		&& flags_r[`BIT_ROLE_SWAP] |=> flags_r[`BIT_ROLE_SWAP])
		else $error("zero written to clear changed a flag");

	a_set_flags: assert property (
		wr_to(`OFS_SET) |=>
		(flags_r & $past(wdata_i[7:0]) & `FLAG_MASK)
		== ($past(wdata_i[7:0]) & `FLAG_MASK))
		else $error("set write did not set flags");

	a_irq_gate: assert property (
		(flags_r[`BIT_POWER_ERR] && control_r[`BIT_POWER_ERR]
		|| flags_r[`BIT_SUSP_TMO] && control_r[`BIT_SUSP_TMO])
		|-> irq_o)
		else $error("enabled flag does not raise interrupt");

	a_irq_masked: assert property (
		(flags_r & control_r[7:0]) == 8'h00 |-> !irq_o)
		else $error("interrupt without enabled flag");

	a_irq_held: assert property (
		irq_o && !wr_to(`OFS_CLEAR) && !wr_to(`OFS_CONTROL)
		|=> irq_o)
		else $error("interrupt dropped without clear");

	a_version: assert property (
		rd_at(`OFS_VERSION) |=>
		rdata_o[11:0] == VERSION_NUM && rdata_o[19:16] == VARIANT_NUM
		&& rdata_o[31:20] == 12'h000)
		else $error("version word wrong");

	a_features: assert property (
		rd_at(`OFS_FEATURES) |=> rdata_o[31:16] == 16'h0000
		&& rdata_o[3:0] == FEAT_EPT_MAX && rdata_o[6:4] == FEAT_DMA_CHAN)
		else $error("features word wrong");

	c_edge_irq: cover property (
		pwr_edge && control_r[`BIT_POWER_EDGE] ##1 irq_o);
	c_role_clear: cover property (
		role_swap_evt_i ##[1:8] wr_to(`OFS_CLEAR) ##1 !irq_o);
	c_hw_drop: cover property (
		power_request_r && hw_drop ##1 !power_request_r);
	c_set_clear: cover property (
		req_set ##[1:4] req_clr ##1 !power_request_r);

endmodule

//--- testbench/cable_model.sv
// far side of the cable: bus power and ident lines, always driven
module cable_model (
	input wire logic clk_i,
	output logic power_o,
	output logic ident_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		power_o = 1'b0;
		ident_o = 1'b1;
	end
	task automatic drive(input logic p, input logic id);
		@(posedge clk_i);
		power_o <= p;
		ident_o <= id;
	endtask
endmodule

//--- testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [31:0] wdata_i = 32'h00000000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [1:0] speed = 2'h0;
	logic susp = 1'b0;
	logic [2:0] evt = 3'h0;
	logic [31:0] rdata;
	logic pad;
	logic ident;
	logic vbof;
	logic irq;
	logic [2:0] mode;
	int errors = 0;
	int compares = 0;
	always #2.5 clk_i = ~clk_i;
	cable_model u_cable (.clk_i(clk_i), .power_o(pad), .ident_o(ident));
	usb_otg_general_status #(.TIMEOUT_CYCLES(20)) u_dut (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata),
		.bus_power_pad_i(pad),
		.ident_pin_i(ident),
		.link_speed_i(speed),
		.host_suspend_i(susp),
		.role_swap_evt_i(evt[0]),
		.bconn_error_evt_i(evt[1]),
		.power_drop_evt_i(evt[2]),
		.power_supply_control_out_o(vbof),
		.irq_o(irq),
		.controller_enable_o(mode[2]),
		.clock_freeze_o(mode[1]),
		.dual_role_pad_enable_o(mode[0])
	);
	task automatic report_and_stop;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input gstat_pkg::word_t s, input gstat_pkg::word_t e);
		compares++;
		if (s !== e)
		begin
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
			errors++;
		end
	endtask
	task automatic wr(input gstat_pkg::addr_t a, input gstat_pkg::word_t d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input gstat_pkg::addr_t a, output gstat_pkg::word_t d);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rdc(input gstat_pkg::addr_t a, input gstat_pkg::word_t e);
		gstat_pkg::word_t d;
		rd(a, d);
		chk(d, e);
	endtask
	// bounded poll of one status bit
	task automatic wait_bit(input int b, input logic v);
		gstat_pkg::word_t d;
		for (int n = 0; n < 40; n++)
		begin
			rd(16'h0804, d);
			if (d[b] === v)
				return;
		end
		chk(32'(d[b]), 32'(v));
		report_and_stop();
	endtask
	task automatic ev(input logic [2:0] m);
		@(posedge clk_i);
		evt <= m;
		@(posedge clk_i);
		evt <= 3'h0;
	endtask
	task automatic t_reset_ro;
		chk(32'(vbof), 32'h0);
		chk(32'(irq), 32'h0);
		rdc(16'h0804, 32'h00000400);
		rdc(16'h0818, 32'h00000001);
		rdc(16'h081c, 32'h00000011);
		rdc(16'h0808, 32'h00000000);
		rdc(16'h080c, 32'h00000000);
		rdc(16'h0810, 32'h00000000);
		wr(16'h0804, 32'hffffffff);
		rdc(16'h0804, 32'h00000400);
		rdc(16'h0800, 32'h00004000);
		chk(32'(mode), 32'h2);
		wr(16'h0800, 32'hffffffff);
		rdc(16'h0800, 32'h0000f1bb);
		chk(32'(mode), 32'h7);
		chk(32'(vbof), 32'h1);
		chk(32'(irq), 32'h0);
		wr(16'h0800, 32'h00001000);
		chk(32'(mode), 32'h1);
		chk(32'(vbof), 32'h0);
	endtask
	task automatic t_setclr;
		wr(16'h080c, 32'h000002bb);
		rdc(16'h0804, 32'h000006bb);
		chk(32'(vbof), 32'h1);
		chk(32'(irq), 32'h0);
		wr(16'h0808, 32'h0000000a);
		rdc(16'h0804, 32'h000006b1);
		wr(16'h0808, 32'h000002b1);
		rdc(16'h0804, 32'h00000400);
		chk(32'(vbof), 32'h0);
	endtask
	task automatic t_speed;
		gstat_pkg::word_t d;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_i);
			speed <= 2'(i);
			rd(16'h0804, d);
			chk(32'(d[13:12]), 32'(i));
		end
		@(posedge clk_i);
		speed <= 2'h0;
	endtask
	task automatic t_events;
		wr(16'h0800, 32'h00000020);
		ev(3'b010);
		rdc(16'h0804, 32'h00000410);
		chk(32'(irq), 32'h0);
		ev(3'b001);
		rdc(16'h0804, 32'h00000430);
		chk(32'(irq), 32'h1);
		wr(16'h0808, 32'h00000030);
		chk(32'(irq), 32'h0);
	endtask
	task automatic t_power;
		wr(16'h0800, 32'h00000008);
		wr(16'h080c, 32'h00000200);
		ev(3'b100);
		rdc(16'h0804, 32'h00000408);
		chk(32'(vbof), 32'h0);
		chk(32'(irq), 32'h1);
		wr(16'h0808, 32'h00000008);
		wr(16'h0800, 32'h00002100);
		wr(16'h080c, 32'h00000200);
		ev(3'b100);
		rdc(16'h0804, 32'h00000608);
		chk(32'(vbof), 32'h0);
		chk(32'(irq), 32'h0);
		wr(16'h0808, 32'h00000208);
		chk(32'(vbof), 32'h1);
		wr(16'h0800, 32'h00000000);
	endtask
	// pin edges happen with the clock frozen and the controller disabled
	task automatic t_pins;
		wr(16'h0800, 32'h00004000);
		chk(32'(mode), 32'h2);
		u_cable.drive(1'b1, 1'b1);
		wait_bit(1, 1'b1);
		rdc(16'h0804, 32'h00000c02);
		wr(16'h0800, 32'h00004003);
		chk(32'(irq), 32'h1);
		u_cable.drive(1'b1, 1'b0);
		wait_bit(0, 1'b1);
		rdc(16'h0804, 32'h00000803);
		wr(16'h0808, 32'h00000003);
		chk(32'(irq), 32'h0);
		u_cable.drive(1'b0, 1'b1);
		wait_bit(0, 1'b1);
		rdc(16'h0804, 32'h00000403);
		wr(16'h0808, 32'h00000003);
		wr(16'h0800, 32'h00000000);
	endtask
	task automatic t_susp;
		wr(16'h0800, 32'h00008080);
		chk(32'(mode), 32'h4);
		@(posedge clk_i);
		susp <= 1'b1;
		rdc(16'h0804, 32'h00000400);
		wait_bit(7, 1'b1);
		chk(32'(irq), 32'h1);
		@(posedge clk_i);
		susp <= 1'b0;
		wr(16'h0808, 32'h00000080);
		rdc(16'h0804, 32'h00000400);
	endtask
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		#1;
		t_reset_ro();
		t_setclr();
		t_speed();
		t_events();
		t_power();
		t_pins();
		t_susp();
		report_and_stop();
	end
	initial
	begin
		repeat (100000) @(posedge clk_i);
		errors++;
		report_and_stop();
	end
endmodule
